// >>> rtl/upw_dev.sv
/*
 * upw_dev: transceiver end of the parallel link. Catches the width and
 * direction straps at the end of reset, spaces the interface clock edges,
 * presents receive words with their qualifiers and takes transmit words.
 * Assumes the deserializer and serializer sit on the user side on i_clk,
 * and the straps are static pins from outside the clock domain.
 */
// Notes on behaviour
// - receive error flag low ok, high on error
// - wide mode, no transmit: we drive high valid
// - wide mode, transmit: controller drives high valid
// - narrow mode: high-byte valid is meaningless
// - low byte on low lines, qualified by receive valid
// - width strap high: wide path, 30 MHz
// - width strap low: narrow path, 60 MHz
// - narrow bidirectional: upper lines are ignored
// - narrow unidirectional: low receive, high transmit
// - width strap sampled only when reset ends
// - receive valid marks a full holding register
// - controller keeps next word ready during transmit
`timescale 1ns/1ps
module upw_dev
   import upw_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire logic               i_bus_width_sel,   // strap pin
   input  wire logic               i_dir_sel,         // strap pin, high = unidirectional
   upw_link_if.device              link,
   input  wire logic [WORD_W-1:0]  i_rx_data,
   input  wire logic               i_rx_hi_valid,
   input  wire logic               i_rx_strobe,
   input  wire logic               i_rx_active,
   input  wire logic               i_rx_err,
   input  wire logic               i_tx_ready,
   output logic                    o_rx_full,
   output logic [WORD_W-1:0]       o_tx_data,
   output logic                    o_tx_hi_valid,
   output logic                    o_tx_strobe,
   output upw_mode_t               o_mode
);

   typedef struct packed {
      logic              wsync1;
      logic              wsync2;
      logic              dsync1;
      logic              dsync2;
      logic              in_rst;
      upw_mode_t         mode;
      logic              running;
      logic [ACC_W-1:0]  acc;
      logic              rise;
      logic [WORD_W-1:0] hold;
      logic              hold_hi;
      logic              hold_full;
      logic              err_seen;
      logic [WORD_W-1:0] dout;
      logic              oe_lo;
      logic              oe_hi;
      logic              ubv;
      logic              ubv_oe;
      logic              rx_valid;
      logic              rx_err;
      logic              rx_act;
      logic              accept;
      logic [WORD_W-1:0] tx_data;
      logic              tx_hi;
      logic              tx_strobe;
   } upw_dev_state_t;

   localparam upw_dev_state_t RST_VAL = '{
      in_rst: 1'b1,
      mode:   UPW_BIDI8,
      default: '0
   };

   upw_dev_state_t st_reg;
   upw_dev_state_t st_next;
   logic [ACC_W-1:0] step;
   logic [ACC_W:0]   acc_sum;
   logic             drive_rx;

   // interface clock rate follows the caught width mode
   assign step    = (st_reg.mode == UPW_WIDE16) ? ACC_STEP_WIDE : ACC_STEP_NARROW;
   assign acc_sum = {1'b0, st_reg.acc} + {1'b0, step};
   // in unidirectional mode the low lines are always ours
   assign drive_rx = (st_reg.mode == UPW_UNI8) || !link.tx_word_valid;

   // next-state logic; straps keep shifting through reset so the catch is fresh
   always_comb
   begin
      st_next = st_reg;
      st_next.wsync1 = i_bus_width_sel;
      st_next.wsync2 = st_reg.wsync1;
      st_next.dsync1 = i_dir_sel;
      st_next.dsync2 = st_reg.dsync1;
      st_next.tx_strobe = 1'b0;
      st_next.rise = 1'b0;

      // strap catch on the first cycle after reset; later changes do nothing
      st_next.in_rst = 1'b0;
      if (st_reg.in_rst)
      begin
         st_next.mode = upw_mode_of(st_reg.wsync2, st_reg.dsync2);
         st_next.running = 1'b1;
      end

      // edge spacing: average rate is exactly the link rate, jitter one cycle
      if (st_reg.running)
      begin
         if (acc_sum >= {1'b0, ACC_MOD})
         begin
            st_next.acc = ACC_W'(acc_sum - {1'b0, ACC_MOD});
            st_next.rise = 1'b1;
         end
         else
         begin
            st_next.acc = ACC_W'(acc_sum);
         end
      end

      // error is sticky until a new packet starts; a fresh error wins
      if (i_rx_err)
      begin
         st_next.err_seen = 1'b1;
      end
      else if (i_rx_active && !st_reg.rx_act && st_reg.rise)
      begin
         st_next.err_seen = 1'b0;
      end

      // every link-facing output moves only on an interface clock edge
      if (st_reg.rise)
      begin
         st_next.rx_err = st_reg.err_seen || i_rx_err;
         st_next.rx_act = i_rx_active;
         st_next.rx_valid = 1'b0;
         st_next.ubv = 1'b0;
         case (st_reg.mode)
            UPW_WIDE16:
            begin
               st_next.oe_lo = !link.tx_word_valid;
               st_next.oe_hi = !link.tx_word_valid;
               st_next.ubv_oe = !link.tx_word_valid;
            end
            UPW_UNI8:
            begin
               st_next.oe_lo = 1'b1;
               st_next.oe_hi = 1'b0;
               st_next.ubv_oe = 1'b0;
            end
            default:
            begin
               st_next.oe_lo = !link.tx_word_valid;
               st_next.oe_hi = 1'b0;
               st_next.ubv_oe = 1'b0;
            end
         endcase

         // present a full holding register on the data lines, both lanes in wide mode
         if (st_reg.hold_full && drive_rx)
         begin
            st_next.dout = st_reg.hold;
            st_next.rx_valid = 1'b1;
            st_next.ubv = (st_reg.mode == UPW_WIDE16) && st_reg.hold_hi;
            st_next.hold_full = 1'b0;
         end

         // take a word when valid meets our accept on this edge
         if (link.tx_word_valid && st_reg.accept)
         begin
            st_next.tx_strobe = 1'b1;
            case (st_reg.mode)
               UPW_WIDE16:
               begin
                  st_next.tx_data = link.data_bus;
                  st_next.tx_hi = link.upper_byte_valid;
               end
               UPW_UNI8:
               begin
                  st_next.tx_data = {{BYTE_W{1'b0}}, link.data_bus[WORD_W-1:BYTE_W]};
                  st_next.tx_hi = 1'b0;
               end
               default:
               begin
                  st_next.tx_data = {{BYTE_W{1'b0}}, link.data_bus[BYTE_W-1:0]};
                  st_next.tx_hi = 1'b0;
               end
            endcase
         end
         // accept only once valid has been seen, so the bus has turned round
         st_next.accept = i_tx_ready && link.tx_word_valid;
      end

      // the holding register refills only when it was already empty, not in the cycle it is emptied
      if (i_rx_strobe && !st_reg.hold_full)
      begin
         st_next.hold = i_rx_data;
         st_next.hold_hi = i_rx_hi_valid;
         st_next.hold_full = 1'b1;
      end

      if (i_rst)
      begin
         st_next = RST_VAL;
         st_next.wsync1 = i_bus_width_sel;
         st_next.wsync2 = st_reg.wsync1;
         st_next.dsync1 = i_dir_sel;
         st_next.dsync2 = st_reg.dsync1;
      end
   end

   // single state register
   always_ff @(posedge i_clk)
   begin
      st_reg <= st_next;
   end

   // link outputs straight from the state register
   assign link.link_rise      = st_reg.rise;
   assign link.dev_d          = st_reg.dout;
   assign link.dev_oe_lo      = st_reg.oe_lo;
   assign link.dev_oe_hi      = st_reg.oe_hi;
   assign link.dev_ubv_o      = st_reg.ubv;
   assign link.dev_ubv_oe     = st_reg.ubv_oe;
   assign link.rx_word_valid  = st_reg.rx_valid;
   assign link.rx_err_flag    = st_reg.rx_err;
   assign link.rx_in_progress = st_reg.rx_act;
   assign link.tx_accept      = st_reg.accept;

   // user side
   assign o_rx_full     = st_reg.hold_full;
   assign o_tx_data     = st_reg.tx_data;
   assign o_tx_hi_valid = st_reg.tx_hi;
   assign o_tx_strobe   = st_reg.tx_strobe;
   assign o_mode        = st_reg.mode;

endmodule : upw_dev

// >>> rtl/upw_host.sv
/*
 * upw_host: controller end of the parallel link. Catches the straps at
 * the end of reset, receives qualified words and sends a two-word staged
 * transmit stream on the interface clock edges.
 * Assumes the transceiver end supplies the edge strobe on the same i_clk.
 */
`timescale 1ns/1ps
module upw_host
   import upw_pkg::*;
(
   input  wire logic               i_clk,
   input  wire logic               i_rst,
   input  wire logic               i_bus_width_sel,
   input  wire logic               i_dir_sel,
   upw_link_if.host                link,
   input  wire logic [WORD_W-1:0]  i_tx_data,
   input  wire logic               i_tx_hi_valid,
   input  wire logic               i_tx_valid,
   output logic                    o_tx_ready,
   output logic [WORD_W-1:0]       o_rx_data,
   output logic                    o_rx_hi_valid,
   output logic                    o_rx_strobe,
   output logic                    o_rx_err,
   output logic                    o_rx_active
);

   typedef struct packed {
      logic              wsync1;
      logic              wsync2;
      logic              dsync1;
      logic              dsync2;
      logic              in_rst;
      upw_mode_t         mode;
      logic [WORD_W-1:0] cur;
      logic              cur_hi;
      logic              cur_full;
      logic [WORD_W-1:0] pend;
      logic              pend_hi;
      logic              pend_full;
      logic              tx_rdy;
      logic              txv;
      logic              oe_lo;
      logic              oe_hi;
      logic              ubv_oe;
      logic [WORD_W-1:0] rx_data;
      logic              rx_hi;
      logic              rx_strobe;
      logic              rx_err;
      logic              rx_act;
   } upw_host_state_t;

   localparam upw_host_state_t RST_VAL = '{
      in_rst: 1'b1,
      mode:   UPW_BIDI8,
      default: '0
   };

   upw_host_state_t st_reg;
   upw_host_state_t st_next;
   logic            consumed;

   assign consumed = link.link_rise && st_reg.txv && link.tx_accept;

   // next-state logic
   always_comb
   begin
      st_next = st_reg;
      st_next.wsync1 = i_bus_width_sel;
      st_next.wsync2 = st_reg.wsync1;
      st_next.dsync1 = i_dir_sel;
      st_next.dsync2 = st_reg.dsync1;
      st_next.rx_strobe = 1'b0;
      st_next.in_rst = 1'b0;
      if (st_reg.in_rst)
      begin
         st_next.mode = upw_mode_of(st_reg.wsync2, st_reg.dsync2);
      end

      if (consumed)
      begin
         st_next.cur_full = 1'b0;
      end

      if (link.link_rise)
      begin
         // receive: capture on the edge that carries receive valid
         st_next.rx_err = link.rx_err_flag;
         st_next.rx_act = link.rx_in_progress;
         if (link.rx_word_valid)
         begin
            st_next.rx_strobe = 1'b1;
            st_next.rx_data = {{BYTE_W{1'b0}}, link.data_bus[BYTE_W-1:0]};
            st_next.rx_hi = 1'b0;
            if (st_reg.mode == UPW_WIDE16)
            begin
               st_next.rx_data = link.data_bus;
               st_next.rx_hi = link.upper_byte_valid;
            end
         end

         // keep the next word on the bus while valid stays up
         if ((consumed || !st_reg.cur_full) && st_reg.pend_full)
         begin
            st_next.cur = st_reg.pend;
            st_next.cur_hi = st_reg.pend_hi;
            st_next.cur_full = 1'b1;
            st_next.pend_full = 1'b0;
         end
         st_next.txv = st_next.cur_full;

         // shared lanes driven only after valid has stood one edge, so the ends never clash; unidirectional always drives the high lines
         case (st_reg.mode)
            UPW_WIDE16:
            begin
               st_next.oe_lo = st_next.txv && st_reg.txv;
               st_next.oe_hi = st_next.txv && st_reg.txv;
               st_next.ubv_oe = st_next.txv && st_reg.txv;
            end
            UPW_UNI8:
            begin
               st_next.oe_lo = 1'b0;
               st_next.oe_hi = 1'b1;
               st_next.ubv_oe = 1'b0;
            end
            default:
            begin
               st_next.oe_lo = st_next.txv && st_reg.txv;
               st_next.oe_hi = 1'b0;
               st_next.ubv_oe = 1'b0;
            end
         endcase
      end

      // staging slot fills from the user stream, only while ready is shown
      if (i_tx_valid && st_reg.tx_rdy)
      begin
         st_next.pend = i_tx_data;
         st_next.pend_hi = i_tx_hi_valid;
         st_next.pend_full = 1'b1;
      end
      // ready is registered so the user side sees a clean flop output
      st_next.tx_rdy = !st_next.pend_full;

      if (i_rst)
      begin
         st_next = RST_VAL;
         st_next.wsync1 = i_bus_width_sel;
         st_next.wsync2 = st_reg.wsync1;
         st_next.dsync1 = i_dir_sel;
         st_next.dsync2 = st_reg.dsync1;
      end
   end

   // single state register
   always_ff @(posedge i_clk)
   begin
      st_reg <= st_next;
   end

   // word placement on the shared lines depends on the mode
   assign link.host_d = (st_reg.mode == UPW_UNI8) ?
                        {st_reg.cur[BYTE_W-1:0], {BYTE_W{1'b0}}} : st_reg.cur;
   assign link.host_oe_lo    = st_reg.oe_lo;
   assign link.host_oe_hi    = st_reg.oe_hi;
   assign link.host_ubv_o    = st_reg.cur_hi;
   assign link.host_ubv_oe   = st_reg.ubv_oe;
   assign link.tx_word_valid = st_reg.txv;

   assign o_tx_ready    = st_reg.tx_rdy;
   assign o_rx_data     = st_reg.rx_data;
   assign o_rx_hi_valid = st_reg.rx_hi;
   assign o_rx_strobe   = st_reg.rx_strobe;
   assign o_rx_err      = st_reg.rx_err;
   assign o_rx_active   = st_reg.rx_act;

endmodule : upw_host

// >>> rtl/upw_link_if.sv
/*
 * upw_link_if: the parallel link between the transceiver end and the
 * controller end, with one modport for each.
 * Assumes both ends share i_clk; shared pins are resolved here from the
 * output enables, since the design modules never drive high impedance.
 */
`timescale 1ns/1ps
interface upw_link_if
   import upw_pkg::*;
   ();

   logic                link_rise;       // one-cycle strobe: interface clock rising edge
   logic [WORD_W-1:0]   dev_d;
   logic                dev_oe_lo;
   logic                dev_oe_hi;
   logic [WORD_W-1:0]   host_d;
   logic                host_oe_lo;
   logic                host_oe_hi;
   logic                dev_ubv_o;
   logic                dev_ubv_oe;
   logic                host_ubv_o;
   logic                host_ubv_oe;
   logic                rx_word_valid;
   logic                rx_err_flag;
   logic                rx_in_progress;
   logic                tx_accept;
   logic                tx_word_valid;
   wire  [WORD_W-1:0]   data_bus;
   wire                 upper_byte_valid;

   // wire resolution; released lines read low, as a weak pull-down holds them,
   // so a capture from an undriven lane shows up as a data mismatch
   assign data_bus[BYTE_W-1:0] = dev_oe_lo  ? dev_d[BYTE_W-1:0]  :
                                 host_oe_lo ? host_d[BYTE_W-1:0] : 8'h00;
   assign data_bus[WORD_W-1:BYTE_W] = dev_oe_hi  ? dev_d[WORD_W-1:BYTE_W]  :
                                      host_oe_hi ? host_d[WORD_W-1:BYTE_W] : 8'h00;
   assign upper_byte_valid = dev_ubv_oe  ? dev_ubv_o  :
                             host_ubv_oe ? host_ubv_o : 1'b0;

   modport device
   (
      output link_rise, dev_d, dev_oe_lo, dev_oe_hi, dev_ubv_o, dev_ubv_oe,
      output rx_word_valid, rx_err_flag, rx_in_progress, tx_accept,
      input  tx_word_valid, data_bus, upper_byte_valid
   );

   modport host
   (
      output host_d, host_oe_lo, host_oe_hi, host_ubv_o, host_ubv_oe, tx_word_valid,
      input  link_rise, rx_word_valid, rx_err_flag, rx_in_progress, tx_accept,
      input  data_bus, upper_byte_valid
   );

endinterface : upw_link_if

// >>> rtl/upw_pkg.sv
/*
 * upw_pkg: shared constants, mode type and mode decode for the parallel
 * data-path control of a transceiver link and its controller end.
 * Assumes both ends run on one 100 MHz system clock and that the
 * parallel interface clock is carried as a one-cycle rising-edge strobe.
 */
package upw_pkg;

   // data path geometry
   localparam int          BYTE_W          = 8;
   localparam int          WORD_W          = 16;

   // system clock and parallel interface clock rates, in MHz
   localparam int          SYS_CLK_MHZ     = 100;
   localparam int          LINK_MHZ_WIDE   = 30;
   localparam int          LINK_MHZ_NARROW = 60;

   // phase accumulator that spaces the interface clock edges
   localparam int          ACC_W           = 8;
   localparam logic [7:0]  ACC_MOD         = 8'(SYS_CLK_MHZ);
   localparam logic [7:0]  ACC_STEP_WIDE   = 8'(LINK_MHZ_WIDE);
   localparam logic [7:0]  ACC_STEP_NARROW = 8'(LINK_MHZ_NARROW);

   // bus mode caught from the straps when reset ends
   typedef enum logic [1:0]
   {
      UPW_BIDI8,
      UPW_UNI8,
      UPW_WIDE16
   } upw_mode_t;

   // width strap high wins; direction strap only matters in narrow mode
   function automatic upw_mode_t upw_mode_of(input logic wide, input logic uni);
      upw_mode_t m;
      m = UPW_BIDI8;
      if (wide)
      begin
         m = UPW_WIDE16;
      end
      else if (uni)
      begin
         m = UPW_UNI8;
      end
      return m;
   endfunction : upw_mode_of

endpackage : upw_pkg

// >>> test/upw_link_properties.sv
/*
 * upw_link_properties: timing and drive relations on the parallel link.
 * Assumes it is instantiated beside the link that joins both ends, on one clock.
 */
`timescale 1ns/1ps
module upw_link_properties
   import upw_pkg::*;
(
   input  wire logic      i_clk,
   input  wire logic      i_rst,
   input  wire upw_mode_t o_mode,
   input  wire logic      link_rise,
   input  wire logic      dev_oe_lo,
   input  wire logic      dev_oe_hi,
   input  wire logic      host_oe_lo,
   input  wire logic      host_oe_hi,
   input  wire logic      dev_ubv_o,
   input  wire logic      dev_ubv_oe,
   input  wire logic      host_ubv_oe,
   input  wire logic      rx_word_valid,
   input  wire logic      rx_err_flag,
   input  wire logic      tx_accept,
   input  wire logic      tx_word_valid
);
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   a_err_on_rise: assert property (
      $changed(rx_err_flag) |-> $past(link_rise)) else $error("error flag moved off an edge");
   a_ubv_on_rise: assert property (
      $changed(dev_ubv_o) |-> $past(link_rise)) else $error("high valid moved off an edge");
   a_rxv_on_rise: assert property (
      $changed(rx_word_valid) |-> $past(link_rise)) else $error("receive valid moved off an edge");
   a_wide_dev_ubv: assert property (
      o_mode == UPW_WIDE16 && rx_word_valid |-> dev_ubv_oe && !host_ubv_oe)
      else $error("device not driving high valid on receive");
   a_wide_host_ubv: assert property (
      o_mode == UPW_WIDE16 && tx_word_valid && tx_accept |-> host_ubv_oe && !dev_ubv_oe)
      else $error("controller not driving high valid on transmit");
   a_narrow_ubv_free: assert property (
      o_mode != UPW_WIDE16 |-> !dev_ubv_oe && !host_ubv_oe)
      else $error("high valid driven in narrow mode");
   a_rx_low_lane: assert property (
      rx_word_valid |-> dev_oe_lo && !host_oe_lo) else $error("receive byte not on low lines");
   a_uni_lanes: assert property (
      o_mode == UPW_UNI8 && tx_word_valid |-> host_oe_hi && !host_oe_lo && !dev_oe_hi)
      else $error("unidirectional transmit lanes wrong");
   a_mode_locked: assert property (
      !$past(i_rst) && !$past(i_rst, 2) |-> $stable(o_mode)) else $error("mode changed after reset");
   a_wide_spacing: assert property (
      o_mode == UPW_WIDE16 && link_rise |-> ##1 !link_rise ##1 !link_rise ##[1:2] link_rise)
      else $error("wide edge spacing wrong");
   a_narrow_spacing: assert property (
      o_mode != UPW_WIDE16 && link_rise |-> ##[1:2] link_rise)
      else $error("narrow edge spacing wrong");

   // main traffic kinds seen at least once
   cover property (o_mode == UPW_WIDE16 && rx_word_valid);
   cover property (o_mode == UPW_UNI8 && tx_word_valid && tx_accept);
   cover property ($rose(rx_err_flag));
endmodule : upw_link_properties

// >>> test/utmi_parallel_width_valid_ctrl_bench.sv
/*
 * utmi_parallel_width_valid_ctrl_bench: both link ends joined, driven from user sides.
 * Assumes the package, link, both ends and the checker are compiled before it.
 */
`timescale 1ns/1ps
module utmi_parallel_width_valid_ctrl_bench
   import upw_pkg::*;
   ();
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        wide_sel = 1'b0;
   logic        dir_sel = 1'b0;
   logic        cur_w = 1'b0;
   logic [15:0] rx_data = 16'h0000;
   logic [15:0] tx_data = 16'h0000;
   logic        rx_hv = 1'b0;
   logic        rx_strobe = 1'b0;
   logic        rx_active = 1'b0;
   logic        rx_err = 1'b0;
   logic        tx_ready = 1'b1;
   logic        tx_hv = 1'b0;
   logic        tx_valid = 1'b0;
   logic        rx_full, d_tx_hv, d_tx_strobe, h_tx_ready;
   logic        h_rx_hv, h_rx_strobe, h_rx_err, h_rx_active;
   logic [15:0] d_tx_data, h_rx_data;
   upw_mode_t   mode;
   logic [16:0] rx_q[$], tx_q[$];
   logic [16:0] exp_v;
   int          seed = 40;
   int          errors = 0;
   int          checks = 0;
   int          rises;

   always #5 i_clk = ~i_clk;

   upw_link_if link_if ();
   upw_dev upw_dev_inst (.i_clk(i_clk), .i_rst(i_rst), .i_bus_width_sel(wide_sel),
      .i_dir_sel(dir_sel), .link(link_if), .i_rx_data(rx_data), .i_rx_hi_valid(rx_hv),
      .i_rx_strobe(rx_strobe), .i_rx_active(rx_active), .i_rx_err(rx_err),
      .i_tx_ready(tx_ready), .o_rx_full(rx_full), .o_tx_data(d_tx_data),
      .o_tx_hi_valid(d_tx_hv), .o_tx_strobe(d_tx_strobe), .o_mode(mode));
   upw_host upw_host_inst (.i_clk(i_clk), .i_rst(i_rst), .i_bus_width_sel(wide_sel),
      .i_dir_sel(dir_sel), .link(link_if), .i_tx_data(tx_data), .i_tx_hi_valid(tx_hv),
      .i_tx_valid(tx_valid), .o_tx_ready(h_tx_ready), .o_rx_data(h_rx_data),
      .o_rx_hi_valid(h_rx_hv), .o_rx_strobe(h_rx_strobe), .o_rx_err(h_rx_err),
      .o_rx_active(h_rx_active));
   upw_link_properties upw_link_properties_inst (.i_clk(i_clk), .i_rst(i_rst), .o_mode(mode),
      .link_rise(link_if.link_rise), .dev_oe_lo(link_if.dev_oe_lo),
      .dev_oe_hi(link_if.dev_oe_hi), .host_oe_lo(link_if.host_oe_lo),
      .host_oe_hi(link_if.host_oe_hi), .dev_ubv_o(link_if.dev_ubv_o),
      .dev_ubv_oe(link_if.dev_ubv_oe), .host_ubv_oe(link_if.host_ubv_oe),
      .rx_word_valid(link_if.rx_word_valid), .rx_err_flag(link_if.rx_err_flag),
      .tx_accept(link_if.tx_accept), .tx_word_valid(link_if.tx_word_valid));

   task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // narrow modes carry one byte, so the upper byte and its flag must read zero
   function automatic logic [16:0] exp_of(input logic [15:0] d, input logic hv);
      return cur_w ? {hv, d} : {9'h000, d[7:0]};
   endfunction : exp_of

   task automatic send_rx(input logic [15:0] d, input logic hv);
      for (int k = 0; k < 300 && rx_full !== 1'b0; k++) @(negedge i_clk);
      rx_data = d;
      rx_hv = hv;
      rx_strobe = 1'b1;
      rx_q.push_back(exp_of(d, hv));
      @(negedge i_clk);
      rx_strobe = 1'b0;
   endtask : send_rx

   task automatic send_tx(input logic [15:0] d, input logic hv);
      for (int k = 0; k < 300 && h_tx_ready !== 1'b1; k++) @(negedge i_clk);
      tx_data = d;
      tx_hv = hv;
      tx_valid = 1'b1;
      tx_q.push_back(exp_of(d, hv));
      @(negedge i_clk);
      tx_valid = 1'b0;
   endtask : send_tx

   // straps flipped after reset must change neither mode nor edge rate
   task automatic run_mode(input logic w, input logic u);
      @(negedge i_clk);
      i_rst = 1'b1;
      wide_sel = w;
      dir_sel = u;
      cur_w = w;
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (2) @(negedge i_clk);
      wide_sel = ~w;
      dir_sel = ~u;
      rises = 0;
      repeat (100)
      begin
         @(negedge i_clk);
         rises += int'(link_if.link_rise === 1'b1);
      end
      chk("mode", 17'(mode), w ? 17'(UPW_WIDE16) : u ? 17'(UPW_UNI8) : 17'(UPW_BIDI8));
      chk("edges", 17'(rises), w ? 17'h1E : 17'h3C);
      // both directions at once forces turnaround on the shared lines
      fork
         for (int k = 0; k < 6; k++) send_rx(16'($random(seed)), 1'($random(seed)));
         for (int k = 0; k < 6; k++) send_tx(16'($random(seed)), 1'($random(seed)));
      join
      for (int k = 0; k < 3000 && rx_q.size() + tx_q.size() != 0; k++) @(negedge i_clk);
      chk("drained", 17'(rx_q.size() + tx_q.size()), 17'h0);
      chk("idle", 17'({rx_full, h_tx_ready}), 17'h1);
   endtask : run_mode

   // one-cycle error must stick until a new packet starts
   task automatic err_flag();
      rx_err = 1'b1;
      @(negedge i_clk);
      rx_err = 1'b0;
      repeat (30) @(negedge i_clk);
      chk("err_set", 17'(h_rx_err), 17'h1);
      rx_active = 1'b1;
      repeat (30) @(negedge i_clk);
      chk("err_clear", 17'(h_rx_err), 17'h0);
      chk("active", 17'(h_rx_active), 17'h1);
   endtask : err_flag

   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // serializer stalls about one cycle in four
   always @(negedge i_clk) tx_ready = ($random(seed) % 4) != 0;

   // results are matched in arrival order against the words queued by send_rx and send_tx
   always @(negedge i_clk)
   begin
      if (h_rx_strobe === 1'b1)
      begin
         exp_v = (rx_q.size() > 0) ? rx_q.pop_front() : 17'h1FFFF;
         chk("rx_word", {h_rx_hv, h_rx_data}, exp_v);
      end
      if (d_tx_strobe === 1'b1)
      begin
         exp_v = (tx_q.size() > 0) ? tx_q.pop_front() : 17'h1FFFF;
         chk("tx_word", {d_tx_hv, d_tx_data}, exp_v);
      end
   end

   initial
   begin
      for (int m = 0; m < 3; m++) run_mode(m == 0, m == 1);
      err_flag();
      summarize();
   end

   initial
   begin
      repeat (40000) @(posedge i_clk);
      errors++;
      $display("[FAIL] watchdog expected done seen hang");
      summarize();
   end
endmodule : utmi_parallel_width_valid_ctrl_bench
